// file: core/ctp_prescale.sv
// Purpose: Source clock prescaler for the cascaded timer
// Assumes: high and low clock ticks are pclk-synchronous one-cycle enables
// Notes: Output tick is one pclk cycle after the qualifying source tick
`timescale 1ns/10ps
`include "ctp_params.svh"
module ctp_prescale (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic high_clock_tick,
  input wire logic low_clock_tick,
  input wire logic [2:0] clk_sel,
  input wire logic pwm_mode,
  input wire logic slow_mode,
  input wire logic divider_bypass_bit,
  output logic src_tick
);

  ctp_pkg::ctp_prescale_type r_reg;
  ctp_pkg::ctp_prescale_type r_next;
  logic h11;
  logic h7;
  logic h5;
  logic h3;
  logic h1;
  logic l3;

  // Divided ticks fire when the low divider bits are all ones
  assign h11 = high_clock_tick && (&r_reg.high_div[`CTP_EXP_11-1:0]);
  assign h7 = high_clock_tick && (&r_reg.high_div[`CTP_EXP_7-1:0]);
  assign h5 = high_clock_tick && (&r_reg.high_div[`CTP_EXP_5-1:0]);
  assign h3 = high_clock_tick && (&r_reg.high_div[`CTP_EXP_3-1:0]);
  assign h1 = high_clock_tick && (&r_reg.high_div[`CTP_EXP_1-1:0]);
  assign l3 = low_clock_tick && (&r_reg.low_div[`CTP_EXP_LOW-1:0]);

  always_comb begin
    r_next = r_reg;
    if (high_clock_tick) begin
      r_next.high_div = r_reg.high_div + 11'h001;
    end
    if (low_clock_tick) begin
      r_next.low_div = r_reg.low_div + 3'h1;
    end
    case (clk_sel)
      // Slowest choice falls to the low clock in bypass or slow modes
      `CTP_CLK_FC_DIV11: r_next.tick = (divider_bypass_bit || slow_mode) ? l3 : h11;
      `CTP_CLK_FC_DIV7: r_next.tick = !slow_mode && h7;
      `CTP_CLK_FC_DIV5: r_next.tick = !slow_mode && h5;
      `CTP_CLK_FC_DIV3: r_next.tick = !slow_mode && h3;
      `CTP_CLK_FS: r_next.tick = pwm_mode && low_clock_tick;
      `CTP_CLK_FC_DIV1: r_next.tick = pwm_mode && !slow_mode && h1;
      `CTP_CLK_FC: r_next.tick = pwm_mode && !slow_mode && high_clock_tick;
      default: r_next.tick = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign src_tick = r_reg.tick;

endmodule

// file: core/ctp_timer_pwm.sv
// Purpose: Cascaded 16-bit interval timer and 16-bit PWM generator, APB slave
// Assumes: APB3/4 master; high and low clock ticks synchronous to pclk
// Notes: Eight-bit, pattern and warm-up modes are not built
//
// Functional notes
// - Timer mode chains both counters into one 16-bit up-counter on source clock.
// - Once run, counter equal to period raises interrupt, clears and keeps counting.
// - Period register is unbuffered; writes act at once, avoid changing while running.
// - Timer clocks: high over 2^11, 2^7, 2^5, 2^3; slowest becomes low over 2^3.
// - PWM mode toggles flip-flop when counter equals width, counting continues.
// - PWM overflow toggles flip-flop again, clears counter, raises interrupt.
// - Flip-flop loads from initial-value bit and reads zero after reset.
// - Pulse pin is the inverse of the flip-flop.
// - Width writes buffered; moved at period interrupt when running, at once when stopped.
// - Width reads return the active stage during PWM output.
// - Stopped PWM holds the pin; init bit applies only in a later write.
// - Run bit is bit 3, initial-value bit is bit 7 of upper control.
// - PWM also offers low clock, high clock over two and high clock.
// - Upper control 04H/0CH is 16-bit timer, 056H/05EH is PWM.
// - Lower control 13H is high over 2^7 cascade, 33H high over 2^3 cascade.
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/10ps
`include "ctp_params.svh"
module ctp_timer_pwm (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic high_clock_tick,
  input wire logic low_clock_tick,
  output logic pulse_out_pin,
  output logic period_interrupt
);

  ctp_pkg::ctp_core_type r_reg;
  ctp_pkg::ctp_core_type r_next;
  ctp_pkg::ctp_mode_type mode;
  logic running;
  logic src_tick;
  logic setup_phase;
  logic wr_en;
  logic mapped;
  logic [2:0] upper_mode;
  logic [2:0] lower_mode;
  logic [2:0] clk_sel;
  logic [31:0] rd_word;

  assign upper_mode = r_reg.upper_control[`CTP_UC_MODE_MSB:`CTP_UC_MODE_LSB];
  assign lower_mode = r_reg.lower_control[`CTP_LC_MODE_MSB:`CTP_LC_MODE_LSB];
  assign clk_sel = r_reg.lower_control[`CTP_LC_CLK_MSB:`CTP_LC_CLK_LSB];

  // Mode needs the lower half in cascade and the upper half naming the mode
  always_comb begin
    mode = ctp_pkg::CTP_MODE_OFF;
    if (lower_mode == `CTP_LMODE_CASCADE) begin
      if (upper_mode == `CTP_UMODE_TIMER16) begin
        mode = ctp_pkg::CTP_MODE_TIMER;
      end else if (upper_mode == `CTP_UMODE_PWM16) begin
        mode = ctp_pkg::CTP_MODE_PWM;
      end
    end
  end

  assign running = r_reg.upper_control[`CTP_UC_RUN_BIT]
    && (mode != ctp_pkg::CTP_MODE_OFF);

  ctp_prescale u_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .high_clock_tick(high_clock_tick),
    .low_clock_tick(low_clock_tick),
    .clk_sel(clk_sel),
    .pwm_mode(mode == ctp_pkg::CTP_MODE_PWM),
    .slow_mode(r_reg.slow_mode),
    .divider_bypass_bit(r_reg.divider_bypass_bit),
    .src_tick(src_tick)
  );

  // APB: answer prepared in the setup cycle, so access never waits
  assign setup_phase = psel && !penable;
  assign wr_en = psel && penable && pwrite && r_reg.pready && !r_reg.pslverr
    && pstrb[0];

  always_comb begin
    mapped = 1'b1;
    rd_word = 32'h00000000;
    case (paddr)
      `CTP_OFF_LOWER_CONTROL: begin
        rd_word[7:0] = r_reg.lower_control;
      end
      `CTP_OFF_UPPER_CONTROL: begin
        rd_word[7:0] = r_reg.upper_control;
      end
      `CTP_OFF_PERIOD_LOW: begin
        rd_word[7:0] = r_reg.period[7:0];
      end
      `CTP_OFF_PERIOD_HIGH: begin
        rd_word[7:0] = r_reg.period[15:8];
      end
      // Reads show the active stage, not the pending value
      `CTP_OFF_WIDTH_LOW: begin
        rd_word[7:0] = r_reg.width_act[7:0];
      end
      `CTP_OFF_WIDTH_HIGH: begin
        rd_word[7:0] = r_reg.width_act[15:8];
      end
      `CTP_OFF_SYSTEM: begin
        rd_word[`CTP_SYS_BYPASS_BIT] = r_reg.divider_bypass_bit;
        rd_word[`CTP_SYS_SLOW_BIT] = r_reg.slow_mode;
      end
      `CTP_OFF_COUNTER: begin
        rd_word[15:0] = r_reg.count;
        rd_word[16] = r_reg.tff;
        rd_word[17] = running;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_comb begin
    r_next = r_reg;
    r_next.irq = 1'b0;

    // Counting; a stopped or unconfigured counter sits at zero
    if (!running) begin
      r_next.count = `CTP_RST_COUNT;
    end else if (src_tick) begin
      case (mode)
        ctp_pkg::CTP_MODE_TIMER: begin
          if (r_reg.count + 16'h0001 == r_reg.period) begin
            r_next.count = `CTP_RST_COUNT;
            r_next.irq = 1'b1;
          end else begin
            r_next.count = r_reg.count + 16'h0001;
          end
        end
        ctp_pkg::CTP_MODE_PWM: begin
          if (r_reg.count == `CTP_COUNT_MAX) begin
            // Overflow closes the cycle and moves the pending width in
            r_next.count = `CTP_RST_COUNT;
            r_next.tff = !r_reg.tff;
            r_next.irq = 1'b1;
            r_next.width_act = r_reg.width_buf;
          end else begin
            r_next.count = r_reg.count + 16'h0001;
            if (r_reg.count + 16'h0001 == r_reg.width_act) begin
              r_next.tff = !r_reg.tff;
            end
          end
        end
        default: begin
          r_next.count = r_reg.count;
        end
      endcase
    end

    // Register writes take effect in the APB access cycle
    if (wr_en) begin
      case (paddr)
        `CTP_OFF_LOWER_CONTROL: begin
          r_next.lower_control = pwdata[7:0];
        end
        `CTP_OFF_UPPER_CONTROL: begin
          r_next.upper_control = pwdata[7:0];
          // Stop write itself leaves the flip-flop, so the pin holds
          if (!r_reg.upper_control[`CTP_UC_RUN_BIT]) begin
            r_next.tff = pwdata[`CTP_UC_INIT_BIT];
          end
        end
        // Unbuffered: a running counter sees the new period at once
        `CTP_OFF_PERIOD_LOW: begin
          r_next.period[7:0] = pwdata[7:0];
        end
        `CTP_OFF_PERIOD_HIGH: begin
          r_next.period[15:8] = pwdata[7:0];
        end
        `CTP_OFF_WIDTH_LOW: begin
          r_next.width_buf[7:0] = pwdata[7:0];
          if (!running) begin
            r_next.width_act[7:0] = pwdata[7:0];
          end
        end
        `CTP_OFF_WIDTH_HIGH: begin
          r_next.width_buf[15:8] = pwdata[7:0];
          if (!running) begin
            r_next.width_act[15:8] = pwdata[7:0];
          end
        end
        `CTP_OFF_SYSTEM: begin
          r_next.divider_bypass_bit = pwdata[`CTP_SYS_BYPASS_BIT];
          r_next.slow_mode = pwdata[`CTP_SYS_SLOW_BIT];
        end
        default: begin
          r_next.count = r_next.count;
        end
      endcase
    end

    // Pin is registered from the next flip-flop value, no extra lag
    r_next.pin = !r_next.tff;

    r_next.pready = setup_phase;
    r_next.pslverr = setup_phase && !mapped;
    r_next.prdata = (setup_phase && !pwrite) ? rd_word : 32'h00000000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.lower_control <= `CTP_RST_CONTROL;
      r_reg.upper_control <= `CTP_RST_CONTROL;
      r_reg.period <= `CTP_RST_PERIOD;
      r_reg.width_buf <= `CTP_RST_WIDTH;
      r_reg.width_act <= `CTP_RST_WIDTH;
      r_reg.count <= `CTP_RST_COUNT;
      r_reg.tff <= 1'b0;
      r_reg.pin <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign pulse_out_pin = r_reg.pin;
  assign period_interrupt = r_reg.irq;

endmodule

// file: pkg/ctp_params.svh
// Purpose: Constants of the cascaded 16-bit timer and PWM block
// Assumes: APB byte addresses on a 12-bit bus; 8-bit registers in the low lane
// Notes: Included by bare name
`ifndef CTP_PARAMS_SVH
`define CTP_PARAMS_SVH

// Register byte offsets
`define CTP_OFF_LOWER_CONTROL 12'h000
`define CTP_OFF_UPPER_CONTROL 12'h004
`define CTP_OFF_PERIOD_LOW 12'h008
`define CTP_OFF_PERIOD_HIGH 12'h00C
`define CTP_OFF_WIDTH_LOW 12'h010
`define CTP_OFF_WIDTH_HIGH 12'h014
`define CTP_OFF_SYSTEM 12'h018
`define CTP_OFF_COUNTER 12'h01C

// Upper control fields
`define CTP_UC_RUN_BIT 3
`define CTP_UC_INIT_BIT 7
`define CTP_UC_MODE_MSB 2
`define CTP_UC_MODE_LSB 0
`define CTP_UMODE_TIMER16 3'h4
`define CTP_UMODE_PWM16 3'h6

// Lower control fields
`define CTP_LC_MODE_MSB 2
`define CTP_LC_MODE_LSB 0
`define CTP_LC_CLK_MSB 6
`define CTP_LC_CLK_LSB 4
`define CTP_LMODE_CASCADE 3'h3

// Source clock select codes
`define CTP_CLK_FC_DIV11 3'h0
`define CTP_CLK_FC_DIV7 3'h1
`define CTP_CLK_FC_DIV5 3'h2
`define CTP_CLK_FC_DIV3 3'h3
`define CTP_CLK_FS 3'h4
`define CTP_CLK_FC_DIV1 3'h5
`define CTP_CLK_FC 3'h6

// Divider exponents
`define CTP_EXP_11 11
`define CTP_EXP_7 7
`define CTP_EXP_5 5
`define CTP_EXP_3 3
`define CTP_EXP_1 1
`define CTP_EXP_LOW 3

// System register fields
`define CTP_SYS_BYPASS_BIT 0
`define CTP_SYS_SLOW_BIT 1

// Reset values and counter maximum
`define CTP_RST_CONTROL 8'h00
`define CTP_RST_PERIOD 16'hFFFF
`define CTP_RST_WIDTH 16'h0000
`define CTP_RST_COUNT 16'h0000
`define CTP_COUNT_MAX 16'hFFFF

`endif

// file: pkg/ctp_pkg.sv
// Purpose: Types of the cascaded 16-bit timer and PWM block
// Assumes: Constants come from ctp_params.svh
// Notes: State of each module is one packed struct
package ctp_pkg;

  typedef enum logic [2:0] {
    CTP_MODE_OFF = 3'b001,
    CTP_MODE_TIMER = 3'b010,
    CTP_MODE_PWM = 3'b100
  } ctp_mode_type;

  typedef struct packed {
    logic [10:0] high_div;
    logic [2:0] low_div;
    logic tick;
  } ctp_prescale_type;

  typedef struct packed {
    logic [7:0] lower_control;
    logic [7:0] upper_control;
    logic [15:0] period;
    logic [15:0] width_buf;
    logic [15:0] width_act;
    logic divider_bypass_bit;
    logic slow_mode;
    logic [15:0] count;
    logic tff;
    logic pin;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ctp_core_type;

endpackage

// file: tb/ctp_checker.sv
// Purpose: Port-level timing checks of the cascaded timer block
// Assumes: Zero wait-state APB slave as handed over
// Notes: Bound to the top module below
`timescale 1ns/10ps
module ctp_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic period_interrupt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  wire logic bad_addr = (paddr > 12'h01C) || (paddr[1:0] != 2'h0);
  ready_after_setup_a: assert property (setup_s |=> access_s)
    else $error("pready missing after setup");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_unmapped_a: assert property (setup_s ##0 bad_addr |=> pslverr)
    else $error("no error on unmapped address");
  err_mapped_a: assert property (setup_s ##0 !bad_addr |=> !pslverr)
    else $error("error on mapped address");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  irq_spacing_a: assert property ($rose(period_interrupt) |=> !period_interrupt [*7])
    else $error("interrupt pulse too long or too close");
endmodule

bind ctp_timer_pwm ctp_checker ctp_checker_i (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .period_interrupt(period_interrupt)
);

// file: tb/tb_ctp_timer_pwm.sv
// Purpose: Self-checking bench of the cascaded timer and PWM block
// Assumes: High clock tick every cycle, low clock tick every second cycle
// Notes: One full PWM period is 65536 cycles, the longest wait
`timescale 1ns/10ps
`include "ctp_params.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %0h got %0h", nm, e, s); end end
module tb_ctp_timer_pwm;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic low_tick = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin;
  logic irq;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;

  ctp_timer_pwm ctp_timer_pwm_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .high_clock_tick(1'b1),
    .low_clock_tick(low_tick), .pulse_out_pin(pin), .period_interrupt(irq));

  initial forever #20 pclk = ~pclk;
  // Low clock ticks every second cycle, slow enough for the counter input
  always @(posedge pclk) low_tick <= ~low_tick;
  // Whole run needs about 70000 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
      output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) bad_count++;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    `CHK("write error", 1'b0, e)
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    `CHK(nm, x, r)
  endtask

  // Bounded waits; a miss shows up as a count or level mismatch
  task automatic wait_irq(output int c);
    c = 0;
    do begin
      @(negedge pclk);
      c++;
    end while (irq !== 1'b1 && c < 70000);
  endtask

  task automatic pin_is(input logic v, input string nm);
    int k;
    k = 0;
    @(negedge pclk);
    while (pin !== v && k < 200) begin
      @(negedge pclk);
      k++;
    end
    `CHK(nm, v, pin)
  endtask

  task automatic t_reset();
    rd(`CTP_OFF_PERIOD_LOW, 32'hFF, "period low reset");
    rd(`CTP_OFF_UPPER_CONTROL, 32'h00, "upper control reset");
    rd(`CTP_OFF_COUNTER, 32'h0, "counter and flip-flop reset");
    @(negedge pclk);
    `CHK("pin after reset", 1'b1, pin)
  endtask

  task automatic t_bus();
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h020, 8'h00, r, e);
    `CHK("unmapped error", 1'b1, e)
    pstrb <= 4'h0;
    wr(`CTP_OFF_PERIOD_LOW, 8'h33);
    pstrb <= 4'hF;
    rd(`CTP_OFF_PERIOD_LOW, 32'hFF, "strobe-less write");
  endtask

  task automatic t_timer();
    logic [7:0] lc [6] = '{8'h03, 8'h13, 8'h23, 8'h33, 8'h03, 8'h03};
    logic [7:0] sy [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02};
    int ex [6] = '{2048, 128, 32, 8, 16, 16};
    int c;
    wr(`CTP_OFF_PERIOD_LOW, 8'h01);
    wr(`CTP_OFF_PERIOD_HIGH, 8'h00);
    // Last two passes: slowest choice falls to the low clock, by bypass then by slow mode
    for (int i = 0; i < 6; i++) begin
      wr(`CTP_OFF_SYSTEM, sy[i]);
      wr(`CTP_OFF_LOWER_CONTROL, lc[i]);
      wr(`CTP_OFF_UPPER_CONTROL, 8'h04);
      wr(`CTP_OFF_UPPER_CONTROL, 8'h0C);
      wait_irq(c);
      wait_irq(c);
      `CHK("timer interval", ex[i], c)
      wr(`CTP_OFF_UPPER_CONTROL, 8'h04);
    end
    wr(`CTP_OFF_SYSTEM, 8'h00);
    wr(`CTP_OFF_LOWER_CONTROL, 8'h33);
    wr(`CTP_OFF_UPPER_CONTROL, 8'h0C);
    wait_irq(c);
    wr(`CTP_OFF_PERIOD_LOW, 8'h02);
    wait_irq(c);
    wait_irq(c);
    `CHK("unbuffered period", 16, c)
    wr(`CTP_OFF_UPPER_CONTROL, 8'h04);
    rd(`CTP_OFF_COUNTER, 32'h0, "counter after stop");
  endtask

  task automatic t_pwm();
    int c;
    wr(`CTP_OFF_LOWER_CONTROL, 8'h63);
    wr(`CTP_OFF_WIDTH_LOW, 8'h10);
    wr(`CTP_OFF_WIDTH_HIGH, 8'h00);
    rd(`CTP_OFF_WIDTH_LOW, 32'h10, "width while stopped");
    wr(`CTP_OFF_UPPER_CONTROL, 8'hD6);
    pin_is(1'b0, "pin from init bit");
    wr(`CTP_OFF_UPPER_CONTROL, 8'hDE);
    pin_is(1'b1, "pin at width match");
    wr(`CTP_OFF_WIDTH_LOW, 8'h20);
    wr(`CTP_OFF_WIDTH_HIGH, 8'h00);
    rd(`CTP_OFF_WIDTH_LOW, 32'h10, "width read while running");
    wait_irq(c);
    `CHK("overflow interrupt seen", 1'b1, irq)
    @(negedge pclk);
    `CHK("pin after overflow", 1'b0, pin)
    rd(`CTP_OFF_WIDTH_LOW, 32'h20, "width after transfer");
    // Old width would have toggled by now, the new one not yet
    repeat (20) @(negedge pclk);
    `CHK("pin before new width", 1'b0, pin)
    pin_is(1'b1, "pin at new width");
    wr(`CTP_OFF_UPPER_CONTROL, 8'hD6);
    @(negedge pclk);
    `CHK("pin held by stop", 1'b1, pin)
    wr(`CTP_OFF_UPPER_CONTROL, 8'hD6);
    @(negedge pclk);
    `CHK("pin set after stop", 1'b0, pin)
    wr(`CTP_OFF_UPPER_CONTROL, 8'h56);
    @(negedge pclk);
    `CHK("pin high on init clear", 1'b1, pin)
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_bus();
    t_timer();
    t_pwm();
    test_done();
  end
endmodule
